// ===== prb_pkg.sv
// Notes on behaviour
// - Registers decode as byte offsets within a 256-byte window selected by a window strobe.
// - Each pin-input register is read-only and returns the sampled level of the port pins.
// - Each output-data register latches a written byte and drives it to pins set as outputs.
// - A direction bit of 0 (reset default) makes the pin an input, 1 makes it an output.
// - On ports E, F and G a pin-mode bit of 0 selects processor I/O, 1 routes latched address out.
// - On ports A, B, D, E and G a driver bit of 0 is push-pull, 1 is open-drain.
// - On ports C and F a driver bit of 0 is the plain driver, 1 selects fast slew rate.
// - On ports A, B, C and F a read-only enable register shows 1 for each pin whose driver is on.
// - Reading an output-cell register returns the cell outputs; writing loads the cell flip-flops.
// - Each mask register blocks processor loads of the output cells of its bank.
// - A mask bit of 0 (default) allows the load of its cell, 1 prevents it, other cells unaffected.
package prb_pkg;
    localparam int PORTS = 7;
    localparam int PA = 0;
    localparam int PB = 1;
    localparam int PC = 2;
    localparam int PD = 3;
    localparam int PE = 4;
    localparam int PF = 5;
    localparam int PG = 6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] OFF_IN [PORTS] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h30, 8'h40, 8'h41};
    localparam logic [7:0] OFF_OUT [PORTS] = '{8'h04, 8'h05, 8'h14, 8'h15, 8'h34, 8'h44, 8'h45};
    localparam logic [7:0] OFF_DIR [PORTS] = '{8'h06, 8'h07, 8'h16, 8'h17, 8'h36, 8'h46, 8'h47};
    localparam logic [7:0] OFF_DRV [PORTS] = '{8'h08, 8'h09, 8'h18, 8'h19, 8'h38, 8'h48, 8'h49};
    // 0xFF marks a register the port lacks; no valid offset uses it
    localparam logic [7:0] OFF_NONE = 8'hFF;
    localparam logic [7:0] OFF_MODE [PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h32, 8'h42, 8'h43};
    localparam logic [7:0] OFF_ICELL [PORTS] = '{8'h0A, 8'h0B, 8'hFF, 8'h1A, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] OFF_OEN [PORTS] = '{8'h0C, 8'h0D, 8'h1C, 8'hFF, 8'hFF, 8'h4C, 8'hFF};
    localparam logic [7:0] OFF_CELL_A = 8'h20;
    localparam logic [7:0] OFF_CELL_B = 8'h21;
    localparam logic [7:0] OFF_MASK_A = 8'h22;
    localparam logic [7:0] OFF_MASK_B = 8'h23;
    // driver-select meaning: open-drain ports vs slew-rate ports
    localparam logic [PORTS-1:0] SLEW_PORTS = 7'b0100100;
endpackage

// ===== prb_port_register_bank.sv
module prb_port_register_bank (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // processor register access
    input wire logic registerWindowSelect,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    // pins, per port
    input wire logic [prb_pkg::PORTS-1:0][7:0] pinIn,
    output logic [prb_pkg::PORTS-1:0][7:0] pinOut,
    output logic [prb_pkg::PORTS-1:0][7:0] pinOe,
    output logic [prb_pkg::PORTS-1:0][7:0] fastSlew,
    // latched address for E, F and G pins
    input wire logic [prb_pkg::PORTS-1:0][7:0] latchedAddr,
    // PLD side
    input wire logic [prb_pkg::PORTS-1:0][7:0] inputCellBit,
    output logic [7:0] cellBankA,
    output logic [7:0] cellBankB
);
    import prb_pkg::*;

    logic [PORTS-1:0][7:0] pinMeta_r, pinSyncA_r, pinSyncB_r, pinLevel_r;
    logic [PORTS-1:0][7:0] outLatch_r, dir_r, drv_r, mode_r;
    logic [PORTS-1:0][7:0] drvVal, drvEn;
    logic [7:0] cellA_r, cellB_r, maskA_r, maskB_r, rdData_nxt;
    logic wrHit, rdHit;
    logic [PORTS-1:0] outWe, dirWe, drvWe, modeWe;
    logic cellAWe, cellBWe, maskAWe, maskBWe;

    assign wrHit = registerWindowSelect & wrStrobe;
    assign rdHit = registerWindowSelect & rdStrobe;

    // one write decode for the window; offsets a port lacks fall to default
    always_comb begin
        outWe = '0;
        dirWe = '0;
        drvWe = '0;
        modeWe = '0;
        cellAWe = 1'b0;
        cellBWe = 1'b0;
        maskAWe = 1'b0;
        maskBWe = 1'b0;
        if (wrHit) begin
            case (regAddr)
                OFF_OUT[PA]: begin
                    outWe[PA] = 1'b1;
                end
                OFF_OUT[PB]: begin
                    outWe[PB] = 1'b1;
                end
                OFF_OUT[PC]: begin
                    outWe[PC] = 1'b1;
                end
                OFF_OUT[PD]: begin
                    outWe[PD] = 1'b1;
                end
                OFF_OUT[PE]: begin
                    outWe[PE] = 1'b1;
                end
                OFF_OUT[PF]: begin
                    outWe[PF] = 1'b1;
                end
                OFF_OUT[PG]: begin
                    outWe[PG] = 1'b1;
                end
                OFF_DIR[PA]: begin
                    dirWe[PA] = 1'b1;
                end
                OFF_DIR[PB]: begin
                    dirWe[PB] = 1'b1;
                end
                OFF_DIR[PC]: begin
                    dirWe[PC] = 1'b1;
                end
                OFF_DIR[PD]: begin
                    dirWe[PD] = 1'b1;
                end
                OFF_DIR[PE]: begin
                    dirWe[PE] = 1'b1;
                end
                OFF_DIR[PF]: begin
                    dirWe[PF] = 1'b1;
                end
                OFF_DIR[PG]: begin
                    dirWe[PG] = 1'b1;
                end
                OFF_DRV[PA]: begin
                    drvWe[PA] = 1'b1;
                end
                OFF_DRV[PB]: begin
                    drvWe[PB] = 1'b1;
                end
                OFF_DRV[PC]: begin
                    drvWe[PC] = 1'b1;
                end
                OFF_DRV[PD]: begin
                    drvWe[PD] = 1'b1;
                end
                OFF_DRV[PE]: begin
                    drvWe[PE] = 1'b1;
                end
                OFF_DRV[PF]: begin
                    drvWe[PF] = 1'b1;
                end
                OFF_DRV[PG]: begin
                    drvWe[PG] = 1'b1;
                end
                OFF_MODE[PE]: begin
                    modeWe[PE] = 1'b1;
                end
                OFF_MODE[PF]: begin
                    modeWe[PF] = 1'b1;
                end
                OFF_MODE[PG]: begin
                    modeWe[PG] = 1'b1;
                end
                OFF_CELL_A: begin
                    cellAWe = 1'b1;
                end
                OFF_CELL_B: begin
                    cellBWe = 1'b1;
                end
                OFF_MASK_A: begin
                    maskAWe = 1'b1;
                end
                OFF_MASK_B: begin
                    maskBWe = 1'b1;
                end
                default: begin
                    outWe = '0;
                end
            endcase
        end
    end

    // pins are asynchronous: three stages, change accepted when last two agree
    always_ff @(posedge sys_clk) begin
        pinMeta_r <= pinIn;
        pinSyncA_r <= pinMeta_r;
        pinSyncB_r <= pinSyncA_r;
    end

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    pinLevel_r[p] <= RESET_BYTE;
                end else begin
                    for (int b = 0; b < 8; b++) begin
                        if (pinSyncA_r[p][b] == pinSyncB_r[p][b]) begin
                            pinLevel_r[p][b] <= pinSyncB_r[p][b];
                        end
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    outLatch_r[p] <= RESET_BYTE;
                    dir_r[p] <= RESET_BYTE;
                    drv_r[p] <= RESET_BYTE;
                    mode_r[p] <= RESET_BYTE;
                end else begin
                    if (outWe[p]) begin
                        outLatch_r[p] <= wrData;
                    end
                    if (dirWe[p]) begin
                        dir_r[p] <= wrData;
                    end
                    if (drvWe[p]) begin
                        drv_r[p] <= wrData;
                    end
                    if (modeWe[p]) begin
                        mode_r[p] <= wrData;
                    end
                end
            end

            // pin mode picks the source; address-out pins are enabled whatever the direction bit
            always_comb begin
                for (int b = 0; b < 8; b++) begin
                    if (mode_r[p][b]) begin
                        drvVal[p][b] = latchedAddr[p][b];
                        drvEn[p][b] = 1'b1;
                    end else begin
                        drvVal[p][b] = outLatch_r[p][b];
                        drvEn[p][b] = dir_r[p][b];
                    end
                end
            end

            // open-drain only pulls low, so drive enable follows a low value
            always_comb begin
                if (!SLEW_PORTS[p]) begin
                    pinOut[p] = drvVal[p] & ~drv_r[p];
                    pinOe[p] = drvEn[p] & (~drv_r[p] | ~drvVal[p]);
                    fastSlew[p] = 8'h00;
                end else begin
                    pinOut[p] = drvVal[p];
                    pinOe[p] = drvEn[p];
                    fastSlew[p] = drv_r[p];
                end
            end
        end
    endgenerate

    // write mask protects cells bit by bit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cellA_r <= RESET_BYTE;
            cellB_r <= RESET_BYTE;
            maskA_r <= RESET_BYTE;
            maskB_r <= RESET_BYTE;
        end else begin
            if (cellAWe) begin
                cellA_r <= (wrData & ~maskA_r) | (cellA_r & maskA_r);
            end
            if (cellBWe) begin
                cellB_r <= (wrData & ~maskB_r) | (cellB_r & maskB_r);
            end
            if (maskAWe) begin
                maskA_r <= wrData;
            end
            if (maskBWe) begin
                maskB_r <= wrData;
            end
        end
    end

    assign cellBankA = cellA_r;
    assign cellBankB = cellB_r;

    // read mux; anything unmatched reads zero
    always_comb begin
        case (regAddr)
            OFF_IN[PA]: begin
                rdData_nxt = pinLevel_r[PA];
            end
            OFF_IN[PB]: begin
                rdData_nxt = pinLevel_r[PB];
            end
            OFF_IN[PC]: begin
                rdData_nxt = pinLevel_r[PC];
            end
            OFF_IN[PD]: begin
                rdData_nxt = pinLevel_r[PD];
            end
            OFF_IN[PE]: begin
                rdData_nxt = pinLevel_r[PE];
            end
            OFF_IN[PF]: begin
                rdData_nxt = pinLevel_r[PF];
            end
            OFF_IN[PG]: begin
                rdData_nxt = pinLevel_r[PG];
            end
            OFF_OUT[PA]: begin
                rdData_nxt = outLatch_r[PA];
            end
            OFF_OUT[PB]: begin
                rdData_nxt = outLatch_r[PB];
            end
            OFF_OUT[PC]: begin
                rdData_nxt = outLatch_r[PC];
            end
            OFF_OUT[PD]: begin
                rdData_nxt = outLatch_r[PD];
            end
            OFF_OUT[PE]: begin
                rdData_nxt = outLatch_r[PE];
            end
            OFF_OUT[PF]: begin
                rdData_nxt = outLatch_r[PF];
            end
            OFF_OUT[PG]: begin
                rdData_nxt = outLatch_r[PG];
            end
            OFF_DIR[PA]: begin
                rdData_nxt = dir_r[PA];
            end
            OFF_DIR[PB]: begin
                rdData_nxt = dir_r[PB];
            end
            OFF_DIR[PC]: begin
                rdData_nxt = dir_r[PC];
            end
            OFF_DIR[PD]: begin
                rdData_nxt = dir_r[PD];
            end
            OFF_DIR[PE]: begin
                rdData_nxt = dir_r[PE];
            end
            OFF_DIR[PF]: begin
                rdData_nxt = dir_r[PF];
            end
            OFF_DIR[PG]: begin
                rdData_nxt = dir_r[PG];
            end
            OFF_DRV[PA]: begin
                rdData_nxt = drv_r[PA];
            end
            OFF_DRV[PB]: begin
                rdData_nxt = drv_r[PB];
            end
            OFF_DRV[PC]: begin
                rdData_nxt = drv_r[PC];
            end
            OFF_DRV[PD]: begin
                rdData_nxt = drv_r[PD];
            end
            OFF_DRV[PE]: begin
                rdData_nxt = drv_r[PE];
            end
            OFF_DRV[PF]: begin
                rdData_nxt = drv_r[PF];
            end
            OFF_DRV[PG]: begin
                rdData_nxt = drv_r[PG];
            end
            OFF_MODE[PE]: begin
                rdData_nxt = mode_r[PE];
            end
            OFF_MODE[PF]: begin
                rdData_nxt = mode_r[PF];
            end
            OFF_MODE[PG]: begin
                rdData_nxt = mode_r[PG];
            end
            OFF_ICELL[PA]: begin
                rdData_nxt = inputCellBit[PA];
            end
            OFF_ICELL[PB]: begin
                rdData_nxt = inputCellBit[PB];
            end
            OFF_ICELL[PD]: begin
                rdData_nxt = inputCellBit[PD];
            end
            OFF_OEN[PA]: begin
                rdData_nxt = pinOe[PA];
            end
            OFF_OEN[PB]: begin
                rdData_nxt = pinOe[PB];
            end
            OFF_OEN[PC]: begin
                rdData_nxt = pinOe[PC];
            end
            OFF_OEN[PF]: begin
                rdData_nxt = pinOe[PF];
            end
            OFF_CELL_A: begin
                rdData_nxt = cellA_r;
            end
            OFF_CELL_B: begin
                rdData_nxt = cellB_r;
            end
            OFF_MASK_A: begin
                rdData_nxt = maskA_r;
            end
            OFF_MASK_B: begin
                rdData_nxt = maskB_r;
            end
            default: begin
                rdData_nxt = 8'h00;
            end
        endcase
    end

    // registered read data, valid the edge after a read strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdData <= 8'h00;
        end else if (rdHit) begin
            rdData <= rdData_nxt;
        end
    end
endmodule

// ===== prb_port_register_bank_monitor.sv
module prb_monitor
    import prb_pkg::*;
(
    // bus side
    input wire logic sys_clk, srst, registerWindowSelect, wrStrobe, rdStrobe,
    input wire logic [7:0] regAddr, wrData, rdData, cellBankA, cellBankB,
    // pin and cell side
    input wire logic [prb_pkg::PORTS-1:0][7:0] pinIn, pinOut, pinOe, fastSlew,
    input wire logic [prb_pkg::PORTS-1:0][7:0] latchedAddr, inputCellBit
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire rd = registerWindowSelect && rdStrobe;
    wire wr = registerWindowSelect && wrStrobe;
    a_cella_cause: assert property (!$stable(cellBankA) |-> $past(wr && regAddr == OFF_CELL_A || srst))
        else $error("cell bank A changed without a write");
    a_cellb_cause: assert property (!$stable(cellBankB) |-> $past(wr && regAddr == OFF_CELL_B || srst))
        else $error("cell bank B changed without a write");
    a_rddata_hold: assert property (!$stable(rdData) |-> $past(rd || srst))
        else $error("read data moved without a read");
    a_slew_cause: assert property (!$stable(fastSlew) |-> $past(wr || srst))
        else $error("slew select moved without a write");
    a_oe_cause: assert property (!$stable(pinOe) |-> $past(wr || srst) || !$stable(latchedAddr))
        else $error("pin enable moved without a write");
    a_unmapped_zero: assert property (rd && regAddr inside {8'h02, 8'h24, 8'h4D, 8'hFF} |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    a_cell_read: assert property (rd && regAddr == OFF_CELL_A |=> rdData == $past(cellBankA))
        else $error("cell bank A read mismatch");
    // six quiet samples cover the three-stage pin synchroniser
    a_pin_follow: assert property (($stable(pinIn[PA]) [*6]) ##0 (rd && regAddr == OFF_IN[PA]) |=> rdData == $past(pinIn[PA]))
        else $error("pin read mismatch");
    c_cell_write: cover property (wr && regAddr == OFF_CELL_A);
    c_pin_read: cover property (rd && regAddr == OFF_IN[PA]);
    c_unmapped: cover property (rd && regAddr == 8'h24);
endmodule

bind prb_port_register_bank prb_monitor prb_monitor_i (.*);

// ===== prb_pin_world.sv
module prb_pin_world (
    // pad drivers of the block
    input wire logic [prb_pkg::PORTS-1:0][7:0] pinOut,
    input wire logic [prb_pkg::PORTS-1:0][7:0] pinOe,
    // level outside world puts on released pads
    input wire logic [prb_pkg::PORTS-1:0][7:0] extLevel,
    output logic [prb_pkg::PORTS-1:0][7:0] pinIn
);
    // released open-drain highs fall back to the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ===== prb_port_register_bank_tb.sv
module prb_port_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import prb_pkg::*;
    logic sys_clk, srst, sel, wr, rd, rdSeen;
    logic [7:0] addr, wdat, rdData, cellBankA, cellBankB, v, m;
    logic [PORTS-1:0][7:0] pinIn, pinOut, pinOe, fastSlew, latAddr, inCell, extLevel;
    logic [7:0] expQ[$];
    logic [7:0] unmapped [4] = '{8'h02, 8'h24, 8'h4D, 8'hFF};
    int failures = 0;
    int num_checks = 0;
    prb_port_register_bank prb_port_register_bank_i (.sys_clk(sys_clk), .srst(srst),
        .registerWindowSelect(sel), .wrStrobe(wr), .rdStrobe(rd), .regAddr(addr),
        .wrData(wdat), .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .fastSlew(fastSlew), .latchedAddr(latAddr), .inputCellBit(inCell),
        .cellBankA(cellBankA), .cellBankB(cellBankB));
    prb_pin_world prb_pin_world_i (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
        .pinIn(pinIn));
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // reads carry their expected byte in d; one idle cycle between accesses
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(negedge sys_clk);
        {sel, wr, rd, addr, wdat} = {1'b1, w, !w, a, d};
        if (!w) expQ.push_back(d);
        @(negedge sys_clk);
        {sel, wr, rd} = 3'b000;
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) rdSeen <= sel & rd & !srst;
    always @(negedge sys_clk) if (rdSeen) chk("rdData", rdData, expQ.pop_front());
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(32'hC228));
        {sel, wr, rd, addr, wdat, srst} = '1;
        {sel, wr, rd} = 3'b000;
        for (int p = 0; p < PORTS; p++) begin
            latAddr[p] = 8'($urandom);
            inCell[p] = 8'($urandom);
            extLevel[p] = 8'($urandom);
        end
        repeat (12) @(negedge sys_clk);
        srst = 0;
        for (int i = 0; i < 4; i++) acc(0, 8'(OFF_CELL_A + i), 8'h00);
        for (int p = 0; p < PORTS; p++) begin
            v = 8'($urandom);
            chk("pinOe", pinOe[p], 8'h00);
            acc(0, OFF_DIR[p], 8'h00);
            acc(0, OFF_DRV[p], 8'h00);
            acc(1, OFF_OUT[p], v);
            acc(1, OFF_DIR[p], 8'hFF);
            chk("pinOut", pinOut[p], v);
            chk("pinOe", pinOe[p], 8'hFF);
            acc(0, OFF_OUT[p], v);
            acc(1, OFF_DRV[p], 8'hFF);
            chk("fastSlew", fastSlew[p], SLEW_PORTS[p] ? 8'hFF : 8'h00);
            chk("pinOe", pinOe[p], SLEW_PORTS[p] ? 8'hFF : ~v);
            if (OFF_OEN[p] != OFF_NONE) acc(0, OFF_OEN[p], SLEW_PORTS[p] ? 8'hFF : ~v);
            if (OFF_MODE[p] != OFF_NONE) begin
                acc(1, OFF_DRV[p], 8'h00);
                acc(1, OFF_DIR[p], 8'h00);
                acc(1, OFF_MODE[p], 8'hFF);
                chk("pinOut", pinOut[p], latAddr[p]);
                chk("pinOe", pinOe[p], 8'hFF);
                acc(0, OFF_MODE[p], 8'hFF);
                acc(1, OFF_MODE[p], 8'h00);
            end
            acc(1, OFF_DIR[p], 8'h00);
            acc(1, OFF_IN[p], ~extLevel[p]);
            repeat (6) @(negedge sys_clk);
            acc(0, OFF_IN[p], extLevel[p]);
            if (OFF_ICELL[p] != OFF_NONE) acc(0, OFF_ICELL[p], inCell[p]);
        end
        m = 8'($urandom);
        v = 8'($urandom);
        acc(1, OFF_MASK_A, m);
        acc(1, OFF_MASK_B, ~m);
        acc(1, OFF_CELL_A, v);
        acc(1, OFF_CELL_B, v);
        chk("cellBankA", cellBankA, v & ~m);
        chk("cellBankB", cellBankB, v & m);
        acc(0, OFF_CELL_A, v & ~m);
        acc(0, OFF_MASK_B, ~m);
        acc(1, 8'h24, 8'hA5);
        for (int i = 0; i < 4; i++) acc(0, unmapped[i], 8'h00);
        repeat (3) @(negedge sys_clk);
        stop_test();
    end
endmodule
